//--- design/asrp_pkg.sv
// Purpose: shared constants and types for the serial result port
// Assumes: 32-bit output frame, 3-bit input preamble
// Notes: frame layout positions are named here and used by the port logic
package asrp_pkg;
    localparam int FRAME_BITS = 32;
    localparam int RESULT_BITS = 24;
    localparam int SUB_BITS = 5;
    localparam int FRAME_EOC_POS = 31;
    localparam int FRAME_ZERO_POS = 30;
    localparam int FRAME_SIGN_POS = 29;
    localparam int FRAME_MSB_POS = 28;
    localparam int FRAME_LSB_POS = 5;
    localparam int CFG_BITS = 13;
    localparam int PRE_BITS = 3;
    localparam logic [2:0] PRE_KEEP0 = 3'h0;
    localparam logic [2:0] PRE_KEEP1 = 3'h4;
    localparam logic [2:0] PRE_LOAD = 3'h5;
    localparam logic [5:0] BIT_CNT_ZERO = 6'h00;
    localparam logic [5:0] BIT_CNT_LAST = 6'h20;
    localparam logic [15:0] CONV_CYCLES_DEFAULT = 16'h0400;
    localparam logic [RESULT_BITS-1:0] RESULT_FS_PLUS = 24'h800000;
    localparam logic [RESULT_BITS-1:0] RESULT_FS_MINUS = 24'h7fffff;
    localparam logic [SUB_BITS-1:0] SUB_OVER = 5'h00;
    localparam logic [SUB_BITS-1:0] SUB_UNDER = 5'h1f;

    typedef enum logic [2:0] {
        ASRP_CONVERT = 3'b001,
        ASRP_SLEEP = 3'b010,
        ASRP_READY = 3'b100
    } asrp_conv_state_t;

    typedef struct packed {
        logic polarity_bit;
        logic [RESULT_BITS-1:0] code;
        logic [SUB_BITS-1:0] sub;
        logic over;
        logic under;
    } asrp_sample_t;

    typedef struct packed {
        logic valid;
        logic [CFG_BITS-1:0] word;
    } asrp_cfg_t;
endpackage

//--- design/asrp_port.sv
// Purpose: serial result/status port of a delta-sigma converter
// Assumes: sck from host is its own clock domain; clk is the conversion oscillator
// Notes: the conversion itself is modelled as a programmable cycle count
`timescale 1ns/1ns
`default_nettype none
module asrp_port
    import asrp_pkg::*;
#(
    parameter logic [15:0] CONV_CYCLES = CONV_CYCLES_DEFAULT
) (
    // oscillator domain
    input wire logic clk,
    input wire logic reset,
    // analog result stand-in
    input wire asrp_sample_t sample_in,
    // serial link, sck is the link clock
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    // status toward the core
    output logic conv_busy,
    output asrp_cfg_t cfg_out
);

    // crossings between the two domains:
    // - frame start, frame end and config capture leave the link side as toggles
    // - select is synchronised on its own and edge-tested one stage later
    // - the link bit count never crosses; select high clears it at once, so the
    //   oscillator side could not see it in time to judge an aborted frame
    // - frame_reg and cfg_word_reg are only read while their writer holds them still

    // link domain
    logic [5:0] rise_cnt_reg;
    logic [CFG_BITS-1:0] in_shift_reg;
    logic [FRAME_BITS-1:0] out_shift_reg;
    logic start_tgl_reg;
    logic done_tgl_reg;
    logic cfg_tgl_reg;
    logic [CFG_BITS-1:0] cfg_word_reg;

    // oscillator domain
    asrp_conv_state_t state_reg;
    logic [15:0] conv_cnt_reg;
    logic [FRAME_BITS-1:0] frame_reg;
    logic [2:0] start_sync_reg;
    logic [2:0] done_sync_reg;
    logic [2:0] cfg_sync_reg;
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic eoc_s1_reg;
    logic eoc_s2_reg;
    logic busy_reg;
    logic clocked_reg;
    asrp_cfg_t cfg_reg;
    logic [FRAME_BITS-1:0] frame_next;

    // decoded crossing events
    logic start_seen;
    logic done_seen;
    logic cfg_seen;
    logic cs_rise;

    // a crossed toggle shows up as its last two stages differing
    function automatic logic tgl_edge(input logic [2:0] s);
        return s[2] ^ s[1];
    endfunction

    // bit 30 fixed low, clamps override the packed fields
    function automatic logic [FRAME_BITS-1:0] pack_frame(input asrp_sample_t s);
        logic [FRAME_BITS-1:0] f;
        f = '0;
        f[FRAME_EOC_POS] = 1'b0;
        f[FRAME_ZERO_POS] = 1'b0;
        f[FRAME_SIGN_POS] = s.polarity_bit;
        f[FRAME_MSB_POS:FRAME_LSB_POS] = s.code;
        f[FRAME_LSB_POS-1:0] = s.sub;
        if (s.over) begin
            f[FRAME_SIGN_POS] = 1'b1;
            f[FRAME_MSB_POS:FRAME_LSB_POS] = RESULT_FS_PLUS;
            f[FRAME_LSB_POS-1:0] = SUB_OVER;
        end else if (s.under) begin
            f[FRAME_SIGN_POS] = 1'b0;
            f[FRAME_MSB_POS:FRAME_LSB_POS] = RESULT_FS_MINUS;
            f[FRAME_LSB_POS-1:0] = SUB_UNDER;
        end
        return f;
    endfunction

    always_comb begin
        frame_next = pack_frame(sample_in);
    end

    // link side: cs_n is the frame's own async reset so nothing waits for an sck edge

    // frame events as toggles; not cleared by select so a late select rise cannot lose them
    always_ff @(posedge sck or posedge reset) begin
        if (reset) begin
            start_tgl_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
        end else if (!cs_n) begin
            if (rise_cnt_reg == BIT_CNT_ZERO) begin
                start_tgl_reg <= ~start_tgl_reg;
            end
            if (rise_cnt_reg == BIT_CNT_LAST - 6'h01) begin
                done_tgl_reg <= ~done_tgl_reg;
            end
        end
    end

    // count rising sck edges and shift sdi in; select high clears both at once
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            rise_cnt_reg <= BIT_CNT_ZERO;
            in_shift_reg <= '0;
        end else begin
            if (rise_cnt_reg != BIT_CNT_LAST) begin
                rise_cnt_reg <= rise_cnt_reg + 6'h01;
                in_shift_reg <= {in_shift_reg[CFG_BITS-2:0], sdi};
            end
        end
    end

    // capture the configuration word once 13 bits are in
    always_ff @(posedge sck or posedge reset) begin
        if (reset) begin
            cfg_word_reg <= '0;
            cfg_tgl_reg <= 1'b0;
        end else if (!cs_n && rise_cnt_reg == 6'(CFG_BITS - 1)) begin
            cfg_word_reg <= {in_shift_reg[CFG_BITS-2:0], sdi};
            cfg_tgl_reg <= ~cfg_tgl_reg;
        end
    end

    // output shifting on falling sck; the frame stays stable in clk domain while select is low
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            out_shift_reg <= '0;
        end else if (rise_cnt_reg == BIT_CNT_LAST) begin
            out_shift_reg <= {FRAME_BITS{1'b1}};
        end else if (rise_cnt_reg == 6'h01) begin
            out_shift_reg <= {frame_reg[FRAME_BITS-2:0], 1'b1};
        end else if (rise_cnt_reg != BIT_CNT_ZERO) begin
            out_shift_reg <= {out_shift_reg[FRAME_BITS-2:0], 1'b1};
        end
    end

    // before the first falling edge the pin shows the live flag
    always_comb begin
        if (rise_cnt_reg <= 6'h01 && out_shift_reg == '0) begin
            sdo_out = eoc_s2_reg;
        end else begin
            sdo_out = out_shift_reg[FRAME_BITS-1];
        end
        sdo_oe = ~cs_n;
    end

    // flag from clk domain; two stages on sck would freeze while sck idles, so use clk view
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            eoc_s1_reg <= 1'b1;
            eoc_s2_reg <= 1'b1;
        end else begin
            eoc_s1_reg <= busy_reg;
            eoc_s2_reg <= eoc_s1_reg;
        end
    end

    // frame start and end toggles: two stages, plus one for the change test
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            start_sync_reg <= '0;
            done_sync_reg <= '0;
        end else begin
            start_sync_reg <= {start_sync_reg[1:0], start_tgl_reg};
            done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
        end
    end

    assign start_seen = tgl_edge(start_sync_reg);
    assign done_seen = tgl_edge(done_sync_reg);
    assign cfg_seen = tgl_edge(cfg_sync_reg);
    assign cs_rise = cs_s2_reg & ~cs_s3_reg;

    // remembers that the frame got past its first rising edge; the link count is
    // already cleared by the time the select rise reaches this side
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clocked_reg <= 1'b0;
        end else if (state_reg == ASRP_READY && (done_seen || cs_rise)) begin
            clocked_reg <= 1'b0;
        end else if (state_reg == ASRP_CONVERT && conv_cnt_reg >= CONV_CYCLES - 16'h0001) begin
            clocked_reg <= 1'b0;
        end else if (start_seen) begin
            clocked_reg <= 1'b1;
        end
    end

    // oscillator side: watch select through a two-stage synchroniser plus an edge stage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
        end else begin
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_sync_reg <= '0;
            cfg_reg <= '0;
        end else begin
            cfg_sync_reg <= {cfg_sync_reg[1:0], cfg_tgl_reg};
            if (cfg_seen) begin
                // keep previous unless the preamble asks for a load
                if (cfg_word_reg[CFG_BITS-1 -: PRE_BITS] == PRE_LOAD) begin
                    cfg_reg <= '{valid: 1'b1, word: cfg_word_reg};
                end
            end
        end
    end

    // conversion sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= ASRP_CONVERT;
            conv_cnt_reg <= '0;
            busy_reg <= 1'b1;
            frame_reg <= '0;
        end else begin
            case (state_reg)
                ASRP_CONVERT: begin
                    if (conv_cnt_reg >= CONV_CYCLES - 16'h0001) begin
                        conv_cnt_reg <= '0;
                        busy_reg <= 1'b0;
                        frame_reg <= frame_next;
                        state_reg <= ASRP_SLEEP;
                    end else begin
                        conv_cnt_reg <= conv_cnt_reg + 16'h0001;
                    end
                end
                ASRP_SLEEP: begin
                    if (!cs_s2_reg) begin
                        state_reg <= ASRP_READY;
                    end
                end
                ASRP_READY: begin
                    // a full frame wins over a select rise seen in the same cycle
                    if (done_seen) begin
                        state_reg <= ASRP_CONVERT;
                        busy_reg <= 1'b1;
                    end else if (cs_rise) begin
                        // rising select ends the frame; a frame with clocking restarts
                        if (clocked_reg || start_seen) begin
                            state_reg <= ASRP_CONVERT;
                            busy_reg <= 1'b1;
                        end else begin
                            state_reg <= ASRP_SLEEP;
                        end
                    end
                end
                default: begin
                    state_reg <= ASRP_CONVERT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_busy <= 1'b1;
            cfg_out <= '0;
        end else begin
            conv_busy <= busy_reg;
            cfg_out <= cfg_reg;
        end
    end

endmodule // asrp_port
`default_nettype wire

//--- dv/asrp_port_asserts.sv
// Purpose: concurrent checks on the serial result port
// Assumes: sck may pulse outside frames, where it must be ignored
// Notes: rise count lives in the link domain, cleared by select high
`timescale 1ns/1ns
`default_nettype none
module asrp_port_asserts
    import asrp_pkg::*;
(
    // domains
    input wire logic clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic cs_n,
    // outputs watched
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic conv_busy
);
    logic [5:0] n_reg;
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            n_reg <= 6'h00;
        end else if (n_reg != 6'h3f) begin
            n_reg <= n_reg + 6'h01;
        end
    end
    oe_follows_a: assert property (@(posedge clk) disable iff (reset) sdo_oe == !cs_n)
        else $error("oe wrong");
    busy_flag_a: assert property (@(posedge clk) disable iff (reset) (!cs_n && !sck && n_reg == 6'h00
        && conv_busy && $past(conv_busy, 3) && !$past(cs_n, 3)) |-> sdo_out) else $error("flag low");
    done_flag_a: assert property (@(posedge clk) disable iff (reset) (!cs_n && !sck && n_reg == 6'h00
        && !conv_busy && !$past(conv_busy, 3) && !$past(cs_n, 3)) |-> !sdo_out) else $error("flag high");
    zero_bit_a: assert property (@(posedge sck) disable iff (cs_n) n_reg == 6'h01 |-> !sdo_out)
        else $error("bit30 high");
    end_high_a: assert property (@(posedge clk) disable iff (reset) (!cs_n && !sck && n_reg == 6'h20) |-> sdo_out)
        else $error("no high");
    abort_restart_a: assert property (@(posedge clk) disable iff (reset)
        ($rose(cs_n) && $past(n_reg) != 6'h00) |-> ##[1:8] conv_busy) else $error("no restart");
    quick_release_a: assert property (@(posedge clk) disable iff (reset)
        ($rose(cs_n) && $past(n_reg) == 6'h00 && !conv_busy) |=> !conv_busy [*6]) else $error("restarted");
    sleep_hold_a: assert property (@(posedge clk) disable iff (reset)
        (cs_n [*8] ##0 !conv_busy) |=> !conv_busy) else $error("woke");
endmodule // asrp_port_asserts
bind asrp_port asrp_port_asserts i_asrp_port_asserts (.clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .conv_busy(conv_busy));
`default_nettype wire

//--- dv/asrp_host_model.sv
// Purpose: host master that clocks frames out of the port
// Assumes: sck period 15 ns, low between frames except for stray pulses
// Notes: sdi flips once released so stale data never reads as valid
`timescale 1ns/1ns
`default_nettype none
module asrp_host_model (
    // link toward the port
    output logic sck,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic frame(input logic [12:0] cfg, input int nbits, output logic [31:0] got, output logic tail);
        got = 32'h0;
        cs_n = 1'b0;
        #24;
        for (int i = 0; i < nbits; i++) begin
            sdi = (i < 13) ? cfg[12 - i] : ~sdi;
            #7 sck = 1'b1;
            got = {got[30:0], sdo_oe ? sdo_out : ~got[0]};
            #8 sck = 1'b0;
        end
        #4 tail = sdo_out;
        #6 cs_n = 1'b1;
        sdi = ~sdi;
    endtask
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            #7 sck = 1'b1;
            #8 sck = 1'b0;
        end
    endtask
endmodule // asrp_host_model
`default_nettype wire

//--- dv/adc_serial_result_port_test.sv
// Purpose: self-checking bench for the serial result port
// Assumes: conversion shortened to 16 cycles
// Notes: second and third full frames carry overrange then underrange
`timescale 1ns/1ns
`default_nettype none
module adc_serial_result_port_test;
    import asrp_pkg::*;
    logic clk, reset, sck, cs_n, sdi, sdo_out, sdo_oe, conv_busy, tail;
    asrp_sample_t sample_in;
    asrp_cfg_t cfg_out;
    logic [31:0] got, exp;
    logic [13:0] exp_cfg;
    logic [12:0] cfg;
    logic [2:0] pre [3] = '{PRE_KEEP0, PRE_KEEP1, PRE_LOAD};
    int errors, compares;
    asrp_port #(.CONV_CYCLES(16'h0010)) i_asrp_port (.clk(clk), .reset(reset), .sample_in(sample_in), .sck(sck),
        .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .conv_busy(conv_busy), .cfg_out(cfg_out));
    asrp_host_model i_asrp_host_model (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] exp_frame(asrp_sample_t s);
        if (s.over) return {3'h1, RESULT_FS_PLUS, SUB_OVER};
        if (s.under) return {3'h0, RESULT_FS_MINUS, SUB_UNDER};
        return {2'h0, s.polarity_bit, s.code, s.sub};
    endfunction
    task automatic conclude();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check_word(logic [31:0] g, logic [31:0] e, string m);
        compares++;
        if (g !== e) begin
            errors++;
            $display("mismatch %0t %s %h", $time, m, g);
        end
    endtask
    task automatic rand_sample(int k);
        asrp_sample_t s;
        @(negedge clk);
        s = asrp_sample_t'($urandom);
        s.over = (k == 0) || (k > 1 && $urandom % 5 == 0);
        s.under = (k == 1) || (!s.over && k > 1 && $urandom % 5 == 0);
        sample_in = s;
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 300 && conv_busy !== 1'b0; n++) @(posedge clk);
        if (n == 300) begin
            errors++;
            $display("mismatch %0t busy stuck", $time);
            conclude();
        end
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    initial begin
        #300000;
        errors++;
        $display("mismatch %0t hung", $time);
        conclude();
    end
    initial begin
        errors = 0;
        compares = 0;
        exp_cfg = 14'h0;
        reset = 1'b1;
        sample_in = '0;
        void'($urandom(79));
        repeat (5) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        rand_sample(-1);
        check_word(32'(conv_busy), 32'h1, "busy");
        i_asrp_host_model.frame(13'h0, 0, got, tail);
        check_word(32'(tail), 32'h1, "flag busy");
        for (int k = 0; k < 9; k++) begin
            wait_idle();
            if (k == 4) begin
                i_asrp_host_model.stray(3);
                repeat (4) @(negedge clk);
                check_word(32'(conv_busy), 32'h0, "stray");
            end
            cfg = {pre[k % 3], 10'($urandom)};
            exp = exp_frame(sample_in);
            i_asrp_host_model.frame(cfg, 32, got, tail);
            check_word(got, exp, "frame");
            check_word(32'(tail), 32'h1, "tail");
            if (cfg[12:10] == PRE_LOAD) exp_cfg = {1'b1, cfg};
            rand_sample(k);
            repeat (6) @(negedge clk);
            check_word(32'(cfg_out), 32'(exp_cfg), "cfg");
            check_word(32'(conv_busy), 32'h1, "restart");
        end
        wait_idle();
        exp = exp_frame(sample_in);
        i_asrp_host_model.frame(13'h0, 10, got, tail);
        check_word(32'(got[9:0]), 32'(exp[31:22]), "partial");
        repeat (8) @(negedge clk);
        check_word(32'(conv_busy), 32'h1, "abort");
        wait_idle();
        i_asrp_host_model.frame(13'h0, 0, got, tail);
        check_word(32'(tail), 32'h0, "flag done");
        repeat (8) @(negedge clk);
        check_word(32'(conv_busy), 32'h0, "sleep");
        conclude();
    end
endmodule // adc_serial_result_port_test
`default_nettype wire
